// file: src/iexo_pkg.sv
package iexo_pkg;
    // register byte offsets on the apb bus
    localparam int IEXO_AW = 8;
    localparam logic [7:0] IEXO_OPA_OFS = 8'h00;
    localparam logic [7:0] IEXO_OPB_OFS = 8'h04;
    localparam logic [7:0] IEXO_CMD_OFS = 8'h08;
    localparam logic [7:0] IEXO_ACC_OFS = 8'h0C;
    localparam logic [7:0] IEXO_STAT_OFS = 8'h10;
    localparam logic [7:0] IEXO_CFG_OFS = 8'h14;
    localparam logic [7:0] IEXO_PC_OFS = 8'h18;
    localparam logic [7:0] IEXO_SP_OFS = 8'h1C;
    localparam logic [7:0] IEXO_PARCEL_OFS = 8'h20;
    localparam logic [7:0] IEXO_FSEL_OFS = 8'h24;
    localparam logic [7:0] IEXO_FORM_OFS = 8'h28;
    localparam logic [7:0] IEXO_LEN_OFS = 8'h2C;
    localparam logic [7:0] IEXO_FCODE_OFS = 8'h30;
    // field positions
    localparam int IEXO_ST_CARRY = 0;
    localparam int IEXO_ST_OVF = 1;
    localparam int IEXO_ST_FLAG = 2;
    localparam int IEXO_ST_DIVZ = 3;
    localparam int IEXO_ST_ALIGN = 4;
    localparam int IEXO_CMD_ACC = 4;
    localparam int IEXO_CFG_PCEXT = 0;
    localparam int IEXO_FSEL_IND = 3;
    // fixed values
    localparam logic [3:0] IEXO_ALIGN_CODE = 4'h4;
    localparam logic [31:0] IEXO_WORD_MIN = 32'h80000000;
    localparam logic [31:0] IEXO_ALL_ONES = 32'hFFFFFFFF;
    localparam logic [2:0] IEXO_LEN1 = 3'h1;
    localparam logic [2:0] IEXO_LEN3 = 3'h3;
    localparam logic [2:0] IEXO_LEN5 = 3'h5;

    typedef enum logic [3:0] {
        IEXO_ADD = 4'h0, IEXO_SUB = 4'h1, IEXO_MUL = 4'h2, IEXO_DIV = 4'h3,
        IEXO_REM = 4'h4, IEXO_UNSIGNED_DIVIDE = 4'h5, IEXO_UNSIGNED_REMAINDER = 4'h6, IEXO_TAGGED_ADD = 4'h7,
        IEXO_TAGGED_SUBTRACT = 4'h8, IEXO_COMPARE_EQUAL = 4'h9, IEXO_COMPARE_SIGNED_GREATER = 4'hA, IEXO_COMPARE_UNSIGNED_GREATER = 4'hB,
        IEXO_COPY_CARRY_TO_FLAG = 4'hC, IEXO_COPY_OVERFLOW_TO_FLAG = 4'hD, IEXO_NOP = 4'hE
    } iexo_op_t;

    typedef enum logic [2:0] {
        IEXO_F_IMM5 = 3'h0, IEXO_F_SOFF5 = 3'h1, IEXO_F_F10Z = 3'h2, IEXO_F_F10J = 3'h3,
        IEXO_F_F8Z = 3'h4, IEXO_F_F8ONE = 3'h5, IEXO_F_W16S = 3'h6, IEXO_F_ABS16 = 3'h7
    } iexo_form_t;

    typedef struct packed {
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] acc;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] parcel;
        logic [31:0] formed;
        logic [31:0] prdata;
        logic [3:0] fsel;
        logic [3:0] fcode;
        logic [2:0] plen;
        logic carry;
        logic ovf;
        logic flag;
        logic divz;
        logic alignf;
        logic pcext;
        logic pready;
        logic pslverr;
    } iexo_state_t;

    localparam iexo_state_t IEXO_RESET = '0;
endpackage : iexo_pkg

// file: src/iexo_top.sv
// Behaviour
// - add gives 32-bit sum; carry bit is the adder carry-out.
// - subtract adds two's complement of a to b; carry set when no carry-out.
// - carry set when unsigned sum or product exceeds the largest word.
// - unsigned divide and remainder never set carry.
// - overflow set when signed add, subtract or multiply leaves 32-bit range.
// - signed divide overflows only for most negative word divided by minus one.
// - signed remainder never sets overflow.
// - zero divisor raises divide-by-zero and writes no quotient.
// - remainder matches its divide; unsigned remainder is below the divisor.
// - result goes to operand b, or to the accumulator for accumulator variants.
// - tagged ops with nonzero low two bits set flag and skip the write.
// - tagged ops with clean tags that overflow set flag and skip the write.
// - misaligned indirect field value raises alignment fault code four; scaled stack offsets never fault.
// - flag keeps its value until an instruction or a status register write overwrites it.
// - instructions are 16-bit parcels of length one, three or five.
// - first parcel top bit zero means one parcel.
// - first parcel top bits binary 10 mean three parcels.
// - first parcel top bits binary 11 mean five parcels.
// - 5-bit immediates sign extend; 5-bit stack offsets zero extend, times four, plus sp.
// - 10-bit fields zero extend except jump; 8-bit zero extend except allocate, one filled.
// - 10-bit jump offsets times two; other 10-bit values times four.
// - 16-bit immediate or offset fields sign extend to a word.
// - 16-bit absolute: with pc extension bits 31:29 from pc, 28:16 zero; else upper zero.
`timescale 1ns/100ps
`default_nettype none
module iexo_top
    import iexo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IEXO_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cond_flag
);
    iexo_state_t q;
    iexo_state_t n;

    // apb handshake terms: answer one cycle into the access phase
    logic acc_end;
    logic wr_go;
    logic cmd_go;
    iexo_op_t cmd_op;
    assign acc_end = psel && penable && q.pready;
    assign wr_go = acc_end && pwrite;
    assign cmd_go = wr_go && (paddr == IEXO_CMD_OFS);
    assign cmd_op = iexo_op_t'(pwdata[3:0]);

    // adder, multiplier and divider on the operand registers
    logic [32:0] sum_add;
    logic [32:0] sum_sub;
    logic [63:0] prod_u;
    logic [63:0] prod_s;
    logic ovf_add;
    logic ovf_sub;
    logic ovf_mul;
    logic div_ovf;
    logic divz_in;
    logic tag_bad;
    logic [31:0] dsor;
    logic [31:0] squo;
    logic [31:0] srem;
    logic [31:0] uquo;
    logic [31:0] unsigned_remainder;
    assign sum_add = {1'b0, q.opb} + {1'b0, q.opa};
    assign sum_sub = {1'b0, q.opb} + {1'b0, ~q.opa} + 33'h000000001;
    assign prod_u = {32'h00000000, q.opa} * {32'h00000000, q.opb};
    // both factors widened to 64 bits first so the product is formed at full width
    assign prod_s = $signed({{32{q.opa[31]}}, q.opa}) * $signed({{32{q.opb[31]}}, q.opb});
    assign ovf_add = (q.opa[31] == q.opb[31]) && (sum_add[31] != q.opb[31]);
    assign ovf_sub = (q.opa[31] != q.opb[31]) && (sum_sub[31] != q.opb[31]);
    assign ovf_mul = prod_s[63:32] != {32{prod_s[31]}};
    assign div_ovf = (q.opb == IEXO_WORD_MIN) && (q.opa == IEXO_ALL_ONES);
    assign divz_in = q.opa == 32'h00000000;
    assign tag_bad = (q.opa[1:0] != 2'h0) || (q.opb[1:0] != 2'h0);
    // a zero divisor is replaced so the divider never sees it; the result is dropped anyway
    assign dsor = divz_in ? 32'h00000001 : q.opa;
    assign squo = div_ovf ? IEXO_WORD_MIN : 32'($signed(q.opb) / $signed(dsor));
    assign srem = div_ovf ? 32'h00000000 : 32'($signed(q.opb) % $signed(dsor));
    assign uquo = q.opb / dsor;
    assign unsigned_remainder = q.opb % dsor;

    // operand formation from an instruction field
    function automatic logic [31:0] form_value(input logic [15:0] f, input iexo_form_t k,
                                               input logic [31:0] pc, input logic [31:0] sp,
                                               input logic pcext);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (k)
            IEXO_F_IMM5: v = {{27{f[4]}}, f[4:0]};
            IEXO_F_SOFF5: v = sp + {25'h0000000, f[4:0], 2'h0};
            IEXO_F_F10Z: v = {20'h00000, f[9:0], 2'h0};
            IEXO_F_F10J: v = {{21{f[9]}}, f[9:0], 1'b0};
            IEXO_F_F8Z: v = {24'h000000, f[7:0]};
            IEXO_F_F8ONE: v = {24'hFFFFFF, f[7:0]};
            IEXO_F_W16S: v = {{16{f[15]}}, f[15:0]};
            IEXO_F_ABS16: v = pcext ? {pc[31:29], 13'h0000, f} : {16'h0000, f};
        endcase
        return v;
    endfunction : form_value

    // next state: bus answer, register writes, execution and operand forming
    always_comb begin
        logic [31:0] res;
        logic wr_res;
        logic [31:0] offs;
        iexo_form_t kind;
        res = 32'h00000000;
        wr_res = 1'b0;
        kind = iexo_form_t'(pwdata[2:0]);
        offs = 32'h00000000;
        n = q;
        n.pready = psel && penable && !q.pready;
        n.pslverr = 1'b0;
        if (n.pready) begin
            n.prdata = 32'h00000000;
            unique case (paddr)
                IEXO_OPA_OFS: n.prdata = q.opa;
                IEXO_OPB_OFS: n.prdata = q.opb;
                IEXO_CMD_OFS: n.prdata = 32'h00000000;
                IEXO_ACC_OFS: n.prdata = q.acc;
                IEXO_STAT_OFS: n.prdata = {27'h0000000, q.alignf, q.divz, q.flag, q.ovf, q.carry};
                IEXO_CFG_OFS: n.prdata = {31'h00000000, q.pcext};
                IEXO_PC_OFS: n.prdata = q.pc;
                IEXO_SP_OFS: n.prdata = q.sp;
                IEXO_PARCEL_OFS: n.prdata = q.parcel;
                IEXO_FSEL_OFS: n.prdata = {28'h0000000, q.fsel};
                IEXO_FORM_OFS: n.prdata = q.formed;
                IEXO_LEN_OFS: n.prdata = {29'h00000000, q.plen};
                IEXO_FCODE_OFS: n.prdata = {28'h0000000, q.fcode};
                default: n.pslverr = 1'b1;
            endcase
        end
        // register writes take effect at the edge that ends the access
        if (wr_go) begin
            unique case (paddr)
                IEXO_OPA_OFS: n.opa = pwdata;
                IEXO_OPB_OFS: n.opb = pwdata;
                IEXO_ACC_OFS: n.acc = pwdata;
                IEXO_STAT_OFS: begin
                    n.carry = pwdata[IEXO_ST_CARRY];
                    n.ovf = pwdata[IEXO_ST_OVF];
                    n.flag = pwdata[IEXO_ST_FLAG];
                    n.divz = q.divz && !pwdata[IEXO_ST_DIVZ];
                    n.alignf = q.alignf && !pwdata[IEXO_ST_ALIGN];
                end
                IEXO_CFG_OFS: n.pcext = pwdata[IEXO_CFG_PCEXT];
                IEXO_PC_OFS: n.pc = pwdata;
                IEXO_SP_OFS: n.sp = pwdata;
                IEXO_PARCEL_OFS: begin
                    n.parcel = pwdata;
                    if (!pwdata[15]) begin
                        n.plen = IEXO_LEN1;
                    end else if (!pwdata[14]) begin
                        n.plen = IEXO_LEN3;
                    end else begin
                        n.plen = IEXO_LEN5;
                    end
                end
                IEXO_FSEL_OFS: begin
                    n.fsel = pwdata[3:0];
                    n.formed = form_value(q.parcel[15:0], kind, q.pc, q.sp, q.pcext);
                    offs = (kind == IEXO_F_SOFF5) ? {25'h0000000, q.parcel[4:0], 2'h0} : n.formed;
                    if (pwdata[IEXO_FSEL_IND] && (offs[1:0] != 2'h0)) begin
                        n.alignf = 1'b1;
                        n.fcode = IEXO_ALIGN_CODE;
                    end
                end
                default: n.opa = q.opa;
            endcase
        end
        // execution on a command write; status bits hold unless the op updates them
        if (cmd_go) begin
            unique case (cmd_op)
                IEXO_ADD: begin
                    res = sum_add[31:0];
                    n.carry = sum_add[32];
                    n.ovf = ovf_add;
                    wr_res = 1'b1;
                end
                IEXO_SUB: begin
                    res = sum_sub[31:0];
                    n.carry = !sum_sub[32];
                    n.ovf = ovf_sub;
                    wr_res = 1'b1;
                end
                IEXO_MUL: begin
                    res = prod_u[31:0];
                    n.carry = |prod_u[63:32];
                    n.ovf = ovf_mul;
                    wr_res = 1'b1;
                end
                IEXO_DIV, IEXO_REM, IEXO_UNSIGNED_DIVIDE, IEXO_UNSIGNED_REMAINDER: begin
                    if (divz_in) begin
                        n.divz = 1'b1;
                    end else begin
                        n.carry = 1'b0;
                        n.ovf = (cmd_op == IEXO_DIV) && div_ovf;
                        wr_res = 1'b1;
                        unique case (cmd_op)
                            IEXO_DIV: res = squo;
                            IEXO_REM: res = srem;
                            IEXO_UNSIGNED_DIVIDE: res = uquo;
                            default: res = unsigned_remainder;
                        endcase
                    end
                end
                IEXO_TAGGED_ADD, IEXO_TAGGED_SUBTRACT: begin
                    res = (cmd_op == IEXO_TAGGED_ADD) ? sum_add[31:0] : sum_sub[31:0];
                    n.carry = (cmd_op == IEXO_TAGGED_ADD) ? sum_add[32] : !sum_sub[32];
                    n.ovf = (cmd_op == IEXO_TAGGED_ADD) ? ovf_add : ovf_sub;
                    if (tag_bad || n.ovf) begin
                        n.flag = 1'b1;
                    end else begin
                        wr_res = 1'b1;
                    end
                end
                IEXO_COMPARE_EQUAL: n.flag = q.opb == q.opa;
                IEXO_COMPARE_SIGNED_GREATER: n.flag = $signed(q.opb) > $signed(q.opa);
                IEXO_COMPARE_UNSIGNED_GREATER: n.flag = q.opb > q.opa;
                IEXO_COPY_CARRY_TO_FLAG: begin
                    n.flag = q.carry;
                    n.carry = 1'b0;
                end
                IEXO_COPY_OVERFLOW_TO_FLAG: begin
                    n.flag = q.ovf;
                    n.ovf = 1'b0;
                end
                default: n.flag = q.flag;
            endcase
            if (wr_res) begin
                if (pwdata[IEXO_CMD_ACC]) begin
                    n.acc = res;
                end else begin
                    n.opb = res;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= IEXO_RESET;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign cond_flag = q.flag;

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence add_cmd_s;
        cmd_go && cmd_op == IEXO_ADD;
    endsequence
    sequence tag_bad_s;
        cmd_go && (cmd_op == IEXO_TAGGED_ADD || cmd_op == IEXO_TAGGED_SUBTRACT) && tag_bad;
    endsequence
    sequence zero_div_s;
        cmd_go && cmd_op inside {IEXO_DIV, IEXO_REM, IEXO_UNSIGNED_DIVIDE, IEXO_UNSIGNED_REMAINDER} && divz_in;
    endsequence

    add_carry_a: assert property (add_cmd_s
        |=> q.carry == $past(sum_add[32]) && q.ovf == $past(ovf_add))
        else $error("add carry or overflow wrong");
    sub_borrow_a: assert property (cmd_go && cmd_op == IEXO_SUB |=> q.carry == !$past(sum_sub[32]))
        else $error("subtract borrow wrong");
    mul_carry_a: assert property (cmd_go && cmd_op == IEXO_MUL
        |=> q.carry == ($past(prod_u) > 64'h00000000FFFFFFFF))
        else $error("multiply carry wrong");
    unsigned_divide_carry_a: assert property (cmd_go && (cmd_op == IEXO_UNSIGNED_DIVIDE || cmd_op == IEXO_UNSIGNED_REMAINDER) && !divz_in
        |=> !q.carry)
        else $error("unsigned divide set carry");
    sub_ovf_a: assert property (cmd_go && cmd_op == IEXO_SUB |=> q.ovf == $past(ovf_sub))
        else $error("subtract overflow wrong");
    div_ovf_a: assert property (cmd_go && cmd_op == IEXO_DIV && !divz_in |=> q.ovf == $past(div_ovf))
        else $error("divide overflow wrong");
    rem_ovf_a: assert property (cmd_go && cmd_op == IEXO_REM |=> !q.ovf || $past(divz_in))
        else $error("remainder set overflow");
    div_zero_a: assert property (zero_div_s |=> q.divz && $stable(q.opb) && $stable(q.acc))
        else $error("zero divisor not trapped");
    unsigned_remainder_range_a: assert property (cmd_go && cmd_op == IEXO_UNSIGNED_REMAINDER && !divz_in && !pwdata[IEXO_CMD_ACC]
        |=> q.opb < $past(q.opa))
        else $error("unsigned remainder not below divisor");
    acc_dest_a: assert property ((add_cmd_s and pwdata[IEXO_CMD_ACC])
        |=> $stable(q.opb) && q.acc == $past(sum_add[31:0]))
        else $error("accumulator variant wrote operand");
    tag_fault_a: assert property (tag_bad_s |=> q.flag && $stable(q.opb) && $stable(q.acc))
        else $error("tagged op stored despite tag");
    flag_hold_a: assert property (!cmd_go && !(wr_go && paddr == IEXO_STAT_OFS) |=> $stable(q.flag))
        else $error("flag changed without cause");
    len_five_a: assert property (wr_go && paddr == IEXO_PARCEL_OFS && pwdata[15:14] == 2'h3
        |=> q.plen == IEXO_LEN5)
        else $error("five parcel length not decoded");
    align_a: assert property (wr_go && paddr == IEXO_FSEL_OFS && pwdata[IEXO_FSEL_IND] && pwdata[2:0] == 3'h6
        && q.parcel[1:0] != 2'h0 |=> q.alignf && q.fcode == IEXO_ALIGN_CODE)
        else $error("misaligned indirect offset not faulted");
endmodule : iexo_top
`default_nettype wire

// file: test/iexo_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end
module iexo_top_tb
    import iexo_pkg::*;
;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, cond_flag;
    logic [IEXO_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    integer seed = 32'h30CF39FD;
    int n_errors = 0;
    int checked = 0;
    logic m_c, m_v, m_f, m_z, m_al, m_pcext;
    logic [31:0] acc_m, sp_m, pc_m;
    logic [3:0] m_fc;
    logic [31:0] cor [5] = '{32'h0, 32'h1, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF};

    iexo_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_flag(cond_flag));

    // free running 100 MHz clock
    always #5 clock = ~clock;

    // one apb transfer: setup, access until pready, then an idle edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd,
        output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            n_errors++;
            $display("MISMATCH t=%0t no pready", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, ad, v, d, e);
        `CHK(e, 1'b0)
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] v);
        logic e;
        apb(1'b0, ad, 32'h0, v, e);
        `CHK(e, 1'b0)
    endtask : rd

    // random word, often a boundary value
    function automatic logic [31:0] pick();
        logic [31:0] r;
        r = $random(seed);
        if (r[3:0] < 4'h5) return cor[r[6:4] % 5];
        return $random(seed);
    endfunction : pick

    // expected result and status of one operation
    function automatic logic [31:0] exp_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
        inout logic c, inout logic v, inout logic f, inout logic z, output logic w);
        logic [32:0] s;
        logic [63:0] p, ps;
        logic [31:0] r;
        r = 32'h0;
        w = 1'b0;
        s = (op == 4'h1 || op == 4'h8) ? {1'b0, b} + {1'b0, ~a} + 33'h1 : {1'b0, a} + {1'b0, b};
        case (op)
            4'h0, 4'h1, 4'h7, 4'h8: begin
                r = s[31:0];
                w = 1'b1;
                c = (op == 4'h1 || op == 4'h8) ? ~s[32] : s[32];
                v = (op == 4'h1 || op == 4'h8) ? (a[31] != b[31]) && (r[31] != b[31])
                    : (a[31] == b[31]) && (r[31] != a[31]);
                if (op >= 4'h7 && ((a[1:0] | b[1:0]) != 2'h0 || v)) begin
                    f = 1'b1;
                    w = 1'b0;
                end
            end
            4'h2: begin
                p = {32'h0, a} * {32'h0, b};
                ps = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
                r = p[31:0];
                w = 1'b1;
                c = |p[63:32];
                v = !(&ps[63:31] || ~|ps[63:31]);
            end
            4'h3, 4'h4, 4'h5, 4'h6: begin
                if (a == 32'h0) z = 1'b1;
                else begin
                    w = 1'b1;
                    c = 1'b0;
                    v = (op == 4'h3) && b == IEXO_WORD_MIN && a == IEXO_ALL_ONES;
                    if (b == IEXO_WORD_MIN && a == IEXO_ALL_ONES && op < 4'h5) r = (op == 4'h3) ? IEXO_WORD_MIN : 32'h0;
                    else if (op == 4'h3) r = $signed(b) / $signed(a);
                    else if (op == 4'h4) r = $signed(b) % $signed(a);
                    else if (op == 4'h5) r = b / a;
                    else r = b % a;
                end
            end
            4'h9: f = (a == b);
            4'hA: f = ($signed(b) > $signed(a));
            4'hB: f = (b > a);
            4'hC: begin
                f = c;
                c = 1'b0;
            end
            4'hD: begin
                f = v;
                v = 1'b0;
            end
            default: ;
        endcase
        return r;
    endfunction : exp_op

    // load operands, run one command, check destination and status
    task automatic run_op(input logic [3:0] op, input logic to_acc, input logic [31:0] a, input logic [31:0] b,
        input logic init);
        logic [31:0] d, r;
        logic w;
        if (init) begin
            d = $random(seed);
            {m_f, m_v, m_c} = d[2:0];
            m_z = 1'b0;
            m_al = 1'b0;
            wr(IEXO_STAT_OFS, {27'h0, 2'b11, d[2:0]});
        end
        wr(IEXO_OPA_OFS, a);
        wr(IEXO_OPB_OFS, b);
        wr(IEXO_CMD_OFS, {27'h0, to_acc, op});
        r = exp_op(op, a, b, m_c, m_v, m_f, m_z, w);
        if (w && to_acc) acc_m = r;
        rd(IEXO_OPB_OFS, d);
        `CHK(d, (w && !to_acc) ? r : b)
        rd(IEXO_ACC_OFS, d);
        `CHK(d, acc_m)
        rd(IEXO_STAT_OFS, d);
        `CHK(d[4:0], {m_al, m_z, m_f, m_v, m_c})
        `CHK(cond_flag, m_f)
    endtask : run_op

    // form an operand from the parcel field and check length and alignment
    task automatic do_form(input logic [2:0] k, input logic ind, input logic [15:0] f);
        logic [31:0] d, e;
        wr(IEXO_PARCEL_OFS, {16'h0, f});
        wr(IEXO_FSEL_OFS, {28'h0, ind, k});
        case (k)
            3'h0: e = {{27{f[4]}}, f[4:0]};
            3'h1: e = sp_m + {25'h0, f[4:0], 2'b00};
            3'h2: e = {20'h0, f[9:0], 2'b00};
            3'h3: e = {{21{f[9]}}, f[9:0], 1'b0};
            3'h4: e = {24'h0, f[7:0]};
            3'h5: e = {24'hFFFFFF, f[7:0]};
            3'h6: e = {{16{f[15]}}, f};
            default: e = m_pcext ? {pc_m[31:29], 13'h0, f} : {16'h0, f};
        endcase
        if (ind && k != 3'h1 && e[1:0] != 2'h0) begin
            m_al = 1'b1;
            m_fc = IEXO_ALIGN_CODE;
        end
        rd(IEXO_FORM_OFS, d);
        `CHK(d, e)
        rd(IEXO_LEN_OFS, d);
        `CHK(d[2:0], !f[15] ? IEXO_LEN1 : (!f[14] ? IEXO_LEN3 : IEXO_LEN5))
        rd(IEXO_STAT_OFS, d);
        `CHK(d[4], m_al)
        rd(IEXO_FCODE_OFS, d);
        `CHK(d[3:0], m_fc)
    endtask : do_form

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // stop a hung run
    initial begin
        #(60000 * 10);
        n_errors++;
        $display("MISMATCH t=%0t watchdog timeout", $time);
        end_of_test();
    end

    // main sequence
    initial begin
        logic [31:0] d, a, b;
        logic e;
        {clock, psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'b1;
        {m_c, m_v, m_f, m_z, m_al, m_pcext, acc_m, m_fc} = '0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(IEXO_STAT_OFS, d);
        `CHK(d, 32'h0)
        `CHK(cond_flag, 1'b0)
        sp_m = $random(seed);
        pc_m = $random(seed);
        wr(IEXO_SP_OFS, sp_m);
        wr(IEXO_PC_OFS, pc_m);
        // hand-picked corners
        run_op(4'h3, 1'b0, IEXO_ALL_ONES, IEXO_WORD_MIN, 1'b1);
        run_op(4'h4, 1'b1, IEXO_ALL_ONES, IEXO_WORD_MIN, 1'b1);
        run_op(4'h5, 1'b0, 32'h0, 32'h1234, 1'b1);
        run_op(4'h7, 1'b0, 32'h40000000, 32'h40000000, 1'b1);
        run_op(4'h8, 1'b0, 32'h4, 32'h9, 1'b1);
        run_op(4'h0, 1'b0, IEXO_ALL_ONES, 32'h1, 1'b1);
        run_op(4'hC, 1'b0, 32'h0, 32'h0, 1'b0);
        run_op(4'h9, 1'b0, 32'h5, 32'h5, 1'b1);
        run_op(4'h2, 1'b1, 32'h3, 32'h7, 1'b0);
        run_op(4'h1, 1'b0, 32'h1, 32'h1, 1'b0);
        // random arithmetic, compares and tests across every command
        for (int i = 0; i < 160; i++) begin
            a = pick();
            b = (i % 5 == 0) ? a : pick();
            if (i % 3 != 0) begin
                a[1:0] = 2'h0;
                b[1:0] = 2'h0;
            end
            run_op(4'(i % 16), (i % 16 < 5) ? 1'($random(seed)) : 1'b0, a, b, i % 4 != 3);
        end
        // operand forms, aligned indirect first, then each kind with pc extension both ways
        run_op(4'hE, 1'b0, 32'h0, 32'h0, 1'b1);
        do_form(3'h6, 1'b1, 16'h0104);
        for (int k = 0; k < 8; k++) begin
            for (int r = 0; r < 4; r++) begin
                m_pcext = r[0];
                wr(IEXO_CFG_OFS, {31'h0, m_pcext});
                do_form(3'(k), r == 3, 16'($random(seed)));
            end
        end
        // unmapped address is refused on write and read
        apb(1'b1, 8'h40, 32'hA5A5A5A5, d, e);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h40, 32'h0, d, e);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0)
        end_of_test();
    end
endmodule : iexo_top_tb
`default_nettype wire
